// ==== rtl/boot_loader_map.vh ====
// constants for the boot mode decoder and eprom boot loader
`ifndef BOOT_LOADER_MAP_VH
`define BOOT_LOADER_MAP_VH
// register byte offsets
`define OFS_SYS_CFG 5'h00
`define OFS_WAIT_CFG 5'h04
`define OFS_DMA_CTL 5'h08
`define OFS_INT_IDX 5'h0c
`define OFS_INT_CNT 5'h10
`define OFS_EXT_IDX 5'h14
`define OFS_EXT_CNT 5'h18
`define OFS_STATUS 5'h1c
// system config fields
`define SYS_BS_BIT 0
`define SYS_TRI_BIT 1
// dma control fields
`define DMA_EN_BIT 0
`define DMA_DATA_TYPE_BIT_BIT 5
`define DMA_PM_LO 6
`define DMA_PM_HI 7
`define PM_BYTE 2'h2
// wait config fields
`define WT_WS_LO 0
`define WT_WS_HI 2
`define WT_WM_LO 3
`define WT_WM_HI 4
`define WM_EITHER 2'h0
`define WM_INT_ONLY 2'h1
`define WM_ACK_ONLY 2'h2
`define WM_BOTH 2'h3
// reset values
`define RST_DMA_CTL 12'h4a1
`define RST_INT_IDX 32'h0004_0000
`define RST_EXT_IDX 32'h0080_0000
`define RST_INT_CNT 9'h100
`define RST_EXT_CNT 11'h600
`define RST_WAIT_ST 3'h6
`define RST_WAIT_MD `WM_BOTH
`define INT_MOD 32'h0000_0001
`define EXT_MOD 32'h0000_0001
`define KERNEL_START 32'h0004_0000
`define RESET_VECTOR 32'h0004_0004
`define BYTES_PER_WORD 3'h6
`endif

// ==== rtl/boot_mode_eprom_loader.v ====
// boot mode decoder and eprom kernel loader with avalon-mm registers
`include "boot_loader_map.vh"
// overview of operation:
// the three strap pins are copied into flops on every clock edge of reset,
// so the value seen at the last reset edge decides the boot mode until the
// next reset; software can never change the mode afterwards.
// in eprom mode the loader starts on the first edge after reset is released,
// drives the boot memory select low together with the read strobe, and
// fetches one byte per strobe from the upper data lane.
// six bytes make one instruction word; the first byte ends up in the low
// bits, the sixth in the top bits, and the word is written to internal
// memory with a single-cycle write enable pulse.
// the internal count falls once per word and the external count once per
// byte; when both reach zero the core is released with a one-cycle return
// pulse and its program counter moves to the kernel start.
// all other modes skip the load and go straight to the done state: the host
// and link protocols live elsewhere.
// the register bus answers every access after one wait cycle, so the
// parameter registers can be inspected while a load is running.
// limitation: only one boot channel is modelled, and the core side request
// input is accepted but never gates the select pin, because the select pin
// belongs to dma transfers alone while the boot space bit is set.
// trade-off: the keeper on the acknowledge pin is a plain flop, which adds
// one cycle between the pin and the strobe logic but keeps timing simple.
module boot_mode_eprom_loader #(
    parameter WORDS = 256
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // boot straps
    input wire eprom_boot_strap_i,
    input wire link_boot_strap_i,
    // boot memory select pin, active low
    input wire boot_memory_select_n_i,
    output reg boot_memory_select_n_o,
    output reg boot_memory_select_oe_o,
    // transfer acknowledge pin
    input wire xfer_ack_i,
    output wire xfer_ack_o,
    output wire xfer_ack_oe_o,
    // external port
    input wire [63:0] ext_data_i,
    output reg [31:0] ext_addr_o,
    output reg ext_rd_n_o,
    output wire ext_msel_en_o,
    input wire core_ext_req_i,
    // internal memory write port
    output reg [31:0] imem_addr_o,
    output reg [47:0] imem_wdata_o,
    output reg imem_we_o,
    // core control
    output reg core_idle_o,
    output reg [31:0] core_pc_o,
    output reg return_from_interrupt_o,
    output wire [3:0] boot_mode_o,
    // avalon-mm slave
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o
);
    // fsm states, one-hot
    localparam ST_IDLE = 4'b0001;
    localparam ST_STRB = 4'b0010;
    localparam ST_GAP = 4'b0100;
    localparam ST_DONE = 4'b1000;

    // captured straps
    reg eb_reg, lb_reg, bms_in_reg;
    // decoded mode, one-hot: eprom, link, host, noboot
    wire m_eprom, m_link, m_host, m_noboot;
    // software visible state
    reg bs_reg; // boot space select
    reg tri_reg; // three-state request for select pin
    reg [11:0] dma_ctl_reg;
    reg [2:0] ws_reg; // unbanked wait states
    reg [1:0] wm_reg; // unbanked wait mode
    reg [31:0] int_idx_reg, ext_idx_reg;
    reg [8:0] int_cnt_reg;
    reg [10:0] ext_cnt_reg;
    // transfer machinery
    reg [3:0] state_reg;
    reg [2:0] wait_reg; // strobe cycle counter
    reg [2:0] byte_reg; // byte position in word
    reg [39:0] pack_reg; // bytes gathered so far
    reg ack_keep_reg; // keeper latch on ack
    reg stall_reg;
    reg avs_done_reg;
    wire pm_forced;
    wire ws_met, ack_ok, strobe_end;
    wire [1:0] pm_eff;

    // mode decoding notes:
    // the eprom strap wins over everything else, the link strap needs the
    // select pin high, and with both straps low the select pin chooses host
    // or no-boot; the reserved combination of link high and select low
    // decodes to no mode at all, so boot_mode_o reads zero then.
    // the decode is purely combinational on the captured straps, so it is
    // glitch free after reset and costs no extra cycle.
    // mode decode; eprom strap wins outright
    assign m_eprom = eb_reg;
    assign m_link = ~eb_reg & lb_reg & bms_in_reg;
    assign m_host = ~eb_reg & ~lb_reg & bms_in_reg;
    assign m_noboot = ~eb_reg & ~lb_reg & ~bms_in_reg;
    assign boot_mode_o = {m_noboot, m_host, m_link, m_eprom};

    // straps captured only while reset is held
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            eb_reg <= eprom_boot_strap_i;
            lb_reg <= link_boot_strap_i;
            bms_in_reg <= boot_memory_select_n_i;
        end
    end

    // acknowledge pin notes:
    // while reset is held the block drives the pin high itself, so no
    // external pull-up is needed; after reset the keeper flop just follows
    // the pin. a low driven by another device is therefore seen as a hold
    // off, and with the reset wait mode the strobe is stretched for as long
    // as that low lasts. software must change the wait mode to escape it.
    // ack pulled up in reset, then the keeper follows the pin
    assign xfer_ack_o = 1'b1;
    assign xfer_ack_oe_o = rst_i;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_keep_reg <= 1'b1;
        end else begin
            // a low from another driver latches low, as in silicon
            ack_keep_reg <= xfer_ack_i;
        end
    end

    // byte packing only under boot space select
    assign pm_forced = bs_reg;
    // outside boot space a byte packing request falls back to no packing
    assign pm_eff = pm_forced ? `PM_BYTE :
        (dma_ctl_reg[`DMA_PM_HI:`DMA_PM_LO] == `PM_BYTE) ? 2'h0 :
        dma_ctl_reg[`DMA_PM_HI:`DMA_PM_LO];

    // normal selects are off while boot space is on
    assign ext_msel_en_o = ~bs_reg;

    // strobe timing notes:
    // the wait counter starts at zero when the strobe falls and stops at the
    // programmed number of wait states, so the strobe stays low for one cycle
    // more than that number: seven cycles with the reset setting.
    // the wait mode then decides whether the count, the acknowledge or both must be met;
    // in the either mode whichever comes first ends the strobe.
    // hazard: lowering the wait states below the running count during a
    // strobe lets the counter wrap once before the strobe ends.
    // strobe end: wait states, acknowledge, both or either, by wait mode
    assign ws_met = (wait_reg == ws_reg);
    assign ack_ok = ack_keep_reg;
    assign strobe_end = (wm_reg == `WM_INT_ONLY) ? ws_met :
        (wm_reg == `WM_ACK_ONLY) ? ack_ok :
        (wm_reg == `WM_BOTH) ? (ws_met & ack_ok) :
        (ws_met | ack_ok);

    // state machine notes:
    // idle  - first cycle after reset; starts the first strobe in eprom mode
    //         or finishes at once for every other mode.
    // strobe - read strobe low; waits for the strobe end condition, then
    //         takes the byte from data lines 39..32 at that same edge.
    // gap   - one cycle with the strobe high between two bytes; also the
    //         place where the two counts are tested for the end of the load.
    // done  - the loader rests here until the next reset.
    // the byte is sampled at the edge that ends the strobe, while select and
    // strobe are still low at the pins, so the eprom output is valid then.
    // the address register is loaded from the external index at the start of
    // each strobe and held steady for its whole length.
    // the write enable and the return pulse default to low every cycle, so
    // each of them stands for exactly one cycle.
    // boot dma state machine and parameter registers
    always @(posedge core_clk_i) begin
        imem_we_o <= 1'b0;
        return_from_interrupt_o <= 1'b0;
        if (rst_i) begin
            state_reg <= ST_IDLE;
            dma_ctl_reg <= `RST_DMA_CTL;
            int_idx_reg <= `RST_INT_IDX;
            ext_idx_reg <= `RST_EXT_IDX;
            int_cnt_reg <= WORDS[8:0];
            ext_cnt_reg <= WORDS[10:0] * {8'h00, `BYTES_PER_WORD};
            ws_reg <= `RST_WAIT_ST;
            wm_reg <= `RST_WAIT_MD;
            bs_reg <= 1'b1;
            tri_reg <= 1'b0;
            wait_reg <= 3'h0;
            byte_reg <= 3'h0;
            pack_reg <= 40'h0;
            stall_reg <= 1'b0;
            ext_rd_n_o <= 1'b1;
            ext_addr_o <= 32'h0;
            imem_addr_o <= 32'h0;
            imem_wdata_o <= 48'h0;
            core_idle_o <= 1'b1;
            core_pc_o <= `RESET_VECTOR;
        end else begin
            stall_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (m_eprom) begin
                        // eprom boot: start at once, core stays idle
                        state_reg <= ST_STRB;
                        ext_addr_o <= ext_idx_reg;
                        ext_rd_n_o <= 1'b0;
                        wait_reg <= 3'h0;
                    end else begin
                        // other modes are not loaded here
                        state_reg <= ST_DONE;
                        core_idle_o <= 1'b0;
                        core_pc_o <= `RESET_VECTOR;
                    end
                end
                ST_STRB: begin
                    if (strobe_end) begin
                        ext_rd_n_o <= 1'b1;
                        ext_idx_reg <= ext_idx_reg + `EXT_MOD;
                        ext_cnt_reg <= ext_cnt_reg - 11'h1;
                        if (byte_reg == `BYTES_PER_WORD - 3'h1) begin
                            // sixth byte lands on top; low byte came first
                            imem_wdata_o <= {ext_data_i[39:32], pack_reg};
                            imem_addr_o <= int_idx_reg;
                            imem_we_o <= 1'b1;
                            int_idx_reg <= int_idx_reg + `INT_MOD;
                            int_cnt_reg <= int_cnt_reg - 9'h1;
                            byte_reg <= 3'h0;
                        end else begin
                            pack_reg <= {ext_data_i[39:32], pack_reg[39:8]};
                            byte_reg <= byte_reg + 3'h1;
                        end
                        state_reg <= ST_GAP;
                    end else begin
                        // held off while acknowledge is low
                        stall_reg <= ws_met;
                        if (!ws_met) begin
                            wait_reg <= wait_reg + 3'h1;
                        end
                    end
                end
                ST_GAP: begin
                    if (ext_cnt_reg == 11'h0 && int_cnt_reg == 9'h0) begin
                        // both counts spent: kernel resumes at its start
                        state_reg <= ST_DONE;
                        return_from_interrupt_o <= 1'b1;
                        core_idle_o <= 1'b0;
                        core_pc_o <= `KERNEL_START;
                    end else begin
                        state_reg <= ST_STRB;
                        ext_addr_o <= ext_idx_reg;
                        ext_rd_n_o <= 1'b0;
                        wait_reg <= 3'h0;
                    end
                end
                ST_DONE: begin
                    // loader finished; only software changes remain
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            // register writes from the bus, taken in the answer cycle only;
            // they follow the state machine so software has the last word,
            // and the counts and indexes stay read only to protect the load
            if (avs_write_i && avs_done_reg) begin
                case (avs_address_i)
                    `OFS_SYS_CFG: begin
                        bs_reg <= avs_writedata_i[`SYS_BS_BIT];
                        tri_reg <= avs_writedata_i[`SYS_TRI_BIT];
                    end
                    `OFS_WAIT_CFG: begin
                        ws_reg <= avs_writedata_i[`WT_WS_HI:`WT_WS_LO];
                        wm_reg <= avs_writedata_i[`WT_WM_HI:`WT_WM_LO];
                    end
                    `OFS_DMA_CTL: begin
                        dma_ctl_reg <= avs_writedata_i[11:0];
                    end
                    default: begin
                        // counts and indexes are read only
                    end
                endcase
            end
        end
    end

    // select pin notes:
    // the pin is driven only in eprom mode and only while the three-state
    // bit is clear; it goes low together with each dma strobe and high with
    // its end, so it is never asserted for a core access.
    // clearing the boot space bit forces the pin high at the next edge and
    // hands the bus back to the normal memory selects.
    // select pin: output in eprom mode, asserted only by dma reads
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            boot_memory_select_n_o <= 1'b1;
            boot_memory_select_oe_o <= 1'b0;
        end else begin
            boot_memory_select_oe_o <= m_eprom & ~tri_reg;
            // core requests never assert it
            boot_memory_select_n_o <= ~(bs_reg & (state_reg == ST_IDLE ?
                m_eprom : state_reg == ST_GAP ? ~(ext_cnt_reg == 11'h0 &&
                int_cnt_reg == 9'h0) : state_reg == ST_STRB ? ~strobe_end :
                1'b0));
        end
    end

    // bus answer notes:
    // every read or write sees waitrequest high in its first cycle and low
    // in its second; read data are captured at the first edge and stand at
    // the edge where waitrequest is low, and a write lands at that edge.
    // the done flop clears itself after one cycle, so back-to-back requests
    // each take two cycles.
    // bus answer: one wait cycle, then data
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~avs_done_reg;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            avs_done_reg <= 1'b0;
            avs_readdata_o <= 32'h0;
        end else begin
            avs_done_reg <= (avs_read_i | avs_write_i) & ~avs_done_reg;
            if (avs_read_i && !avs_done_reg) begin
                case (avs_address_i)
                    `OFS_SYS_CFG: avs_readdata_o <= {30'h0, tri_reg, bs_reg};
                    `OFS_WAIT_CFG: avs_readdata_o <= {27'h0, wm_reg, ws_reg};
                    `OFS_DMA_CTL: avs_readdata_o <= {20'h0, dma_ctl_reg};
                    `OFS_INT_IDX: avs_readdata_o <= int_idx_reg;
                    `OFS_INT_CNT: avs_readdata_o <= {23'h0, int_cnt_reg};
                    `OFS_EXT_IDX: avs_readdata_o <= ext_idx_reg;
                    `OFS_EXT_CNT: avs_readdata_o <= {21'h0, ext_cnt_reg};
                    `OFS_STATUS: avs_readdata_o <= {22'h0, pm_eff, stall_reg,
                        state_reg == ST_DONE, boot_mode_o};
                    default: avs_readdata_o <= 32'h0; // unmapped reads zero
                endcase
            end
        end
    end
endmodule // boot_mode_eprom_loader

// ==== testbench/boot_eprom_model.sv ====
// behavioural byte-wide boot eprom on the upper data lane
module boot_eprom_model (
    // clock and pins
    input wire core_clk_i,
    input wire sel_n_i,
    input wire rd_n_i,
    input wire [31:0] addr_i,
    // bench command to answer slowly
    input wire hold_i,
    output logic [63:0] data_o,
    output wire ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] last = 64'h0; // value shown last cycle
    // ack only drops when the bench asks for a slow answer
    assign ack_o = !hold_i;
    // byte on lines 39..32 when selected; a toggling pattern otherwise so stale data fails
    always @* begin
        if (!sel_n_i && !rd_n_i) begin
            data_o = {24'h0, addr_i[7:0] * 8'h07 + 8'h3c, 32'h0};
        end else begin
            data_o = ~last;
        end
    end
    always @(posedge core_clk_i) last <= data_o;
endmodule // boot_eprom_model

// ==== testbench/boot_loader_chk.sv ====
// port assertions for the eprom boot loader
module boot_loader_chk (
    // clock, reset and acknowledge pin
    input logic core_clk_i, rst_i, xfer_ack_i, xfer_ack_o, xfer_ack_oe_o,
    // eprom strobe side
    input logic [31:0] ext_addr_o, input logic ext_rd_n_o, boot_memory_select_n_o,
    // core control and register bus
    input logic return_from_interrupt_o, core_idle_o, input logic [31:0] core_pc_o,
    input logic [3:0] boot_mode_o, input logic avs_read_i, avs_write_i, avs_waitrequest_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] prev_a; // address of the last strobe
    logic seen; // a strobe has happened since reset
    // remember the last strobe address for the step check
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            seen <= 1'b0;
            prev_a <= 32'h0;
        end else if (!ext_rd_n_o) begin
            seen <= 1'b1;
            prev_a <= ext_addr_o;
        end
    end
    // the pull-up only matters in reset, so this one is not disabled by it
    property p_ack_pull; disable iff (1'b0) rst_i |-> xfer_ack_oe_o && xfer_ack_o; endproperty
    a_ack_pull: assert property (p_ack_pull) else $error("ack not held high");
    property p_strobe; $fell(ext_rd_n_o) |-> !ext_rd_n_o [*7]; endproperty
    a_strobe: assert property (p_strobe) else $error("read strobe short");
    property p_sel; !ext_rd_n_o |-> !boot_memory_select_n_o; endproperty
    a_sel: assert property (p_sel) else $error("strobe without select");
    property p_hold; !ext_rd_n_o && $past(!ext_rd_n_o) |-> $stable(ext_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("address moved in strobe");
    property p_step;
        $fell(ext_rd_n_o) |-> ext_addr_o == (seen ? prev_a + 32'h1 : 32'h0080_0000);
    endproperty
    a_step: assert property (p_step) else $error("address step wrong");
    property p_rti;
        return_from_interrupt_o |-> ##[0:1] (!core_idle_o && core_pc_o == 32'h0004_0000);
    endproperty
    a_rti: assert property (p_rti) else $error("no return to kernel");
    property p_idle; core_idle_o |-> core_pc_o == 32'h0004_0004; endproperty
    a_idle: assert property (p_idle) else $error("idle pc wrong");
    property p_mode; $stable(boot_mode_o); endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    c_rti: cover property (return_from_interrupt_o);
    c_stall: cover property (!ext_rd_n_o && !xfer_ack_i);
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule // boot_loader_chk
bind boot_mode_eprom_loader boot_loader_chk i_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .xfer_ack_i(xfer_ack_i), .xfer_ack_o(xfer_ack_o), .xfer_ack_oe_o(xfer_ack_oe_o),
    .ext_addr_o(ext_addr_o), .ext_rd_n_o(ext_rd_n_o), .core_pc_o(core_pc_o),
    .boot_memory_select_n_o(boot_memory_select_n_o), .core_idle_o(core_idle_o),
    .return_from_interrupt_o(return_from_interrupt_o), .boot_mode_o(boot_mode_o),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o));

// ==== testbench/tb_boot_mode_eprom_loader.sv ====
// self-checking bench for the eprom boot loader
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_boot_mode_eprom_loader;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NW = 2; // shortened kernel length
    logic core_clk_i = 1'b0, rst_i = 1'b1, e_s = 1'b0, l_s = 1'b0, bms_drv = 1'b1;
    logic hold = 1'b0, core_ext_req_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0] avs_address_i = 5'h0;
    logic [31:0] avs_writedata_i = 32'h0, ext_addr_o, imem_addr_o, core_pc_o, avs_readdata_o, q;
    logic [63:0] ext_data_i;
    logic [47:0] imem_wdata_o;
    logic [3:0] boot_mode_o;
    logic bms_o, bms_oe, ack_o, ack_oe, ack_m, rd_n, msel_en, we, idle, return_from_interrupt, wreq;
    wire bms_pin = bms_oe ? bms_o : bms_drv;
    wire ack_pin = ack_oe ? ack_o : ack_m;
    int err_total = 0, checked = 0, cyc = 0, run = 0, max_run = 0, stall;
    logic [79:0] wq[$]; // kernel words seen: address and data
    boot_mode_eprom_loader #(.WORDS(NW)) i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .eprom_boot_strap_i(e_s),
        .link_boot_strap_i(l_s), .boot_memory_select_n_i(bms_pin),
        .boot_memory_select_n_o(bms_o), .boot_memory_select_oe_o(bms_oe),
        .xfer_ack_i(ack_pin), .xfer_ack_o(ack_o), .xfer_ack_oe_o(ack_oe),
        .ext_data_i(ext_data_i), .ext_addr_o(ext_addr_o), .ext_rd_n_o(rd_n),
        .ext_msel_en_o(msel_en), .core_ext_req_i(core_ext_req_i),
        .imem_addr_o(imem_addr_o), .imem_wdata_o(imem_wdata_o), .imem_we_o(we),
        .core_idle_o(idle), .core_pc_o(core_pc_o), .return_from_interrupt_o(return_from_interrupt),
        .boot_mode_o(boot_mode_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(wreq));
    boot_eprom_model i_rom (.core_clk_i(core_clk_i), .sel_n_i(bms_pin), .rd_n_i(rd_n),
        .addr_i(ext_addr_o), .hold_i(hold), .data_o(ext_data_i), .ack_o(ack_m));
    always #5 core_clk_i = ~core_clk_i;
    // record kernel writes, longest strobe, and cut a hang short
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (rst_i) begin
            run <= 0;
            max_run <= 0;
        end else if (!rd_n) begin
            run <= run + 1;
        end else begin
            run <= 0;
            if (run > max_run) max_run <= run;
        end
        if (!rst_i && we === 1'b1) wq.push_back({imem_addr_o, imem_wdata_o});
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end
    function automatic logic [3:0] exp_mode(logic e, logic l, logic b);
        if (e) return 4'h1;
        if (l) return b ? 4'h2 : 4'h0;
        return b ? 4'h4 : 4'h8;
    endfunction
    // packed word from the model's byte pattern, first byte lowest
    function automatic logic [47:0] exp_word(int w);
        logic [47:0] x;
        for (int k = 0; k < 6; k++) x[8*k +: 8] = 8'(w * 6 + k) * 8'h07 + 8'h3c;
        return x;
    endfunction
    task automatic do_reset(logic e, logic l, logic b);
        rst_i <= 1'b1;
        e_s <= e;
        l_s <= l;
        bms_drv <= b;
        hold <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        wq.delete();
        rst_i <= 1'b0;
        // second edge: registered outputs of the first one are settled
        repeat (2) @(posedge core_clk_i);
    endtask
    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        if (w) avs_write_i <= 1'b1;
        else avs_read_i <= 1'b1;
        @(posedge core_clk_i);
        while (wreq !== 1'b0 && n < 50) begin
            n++;
            @(posedge core_clk_i);
        end
        if (n == 50) err_total++;
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic wait_rti();
        int n;
        n = 0;
        while (return_from_interrupt !== 1'b1 && n < 3000) begin
            n++;
            @(posedge core_clk_i);
        end
        `CHK("load_end", 1'b1, return_from_interrupt)
        repeat (2) @(posedge core_clk_i);
    endtask
    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h514a));
        // every strap combination; later resets cut loads short on purpose
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2], i[1], i[0]);
            `CHK("mode", exp_mode(i[2], i[1], i[0]), boot_mode_o)
            `CHK("sel_oe", i[2], bms_oe)
            e_s <= 1'($urandom);
            l_s <= 1'($urandom);
            repeat (3) @(posedge core_clk_i);
            `CHK("mode_kept", exp_mode(i[2], i[1], i[0]), boot_mode_o)
            $display("test 1 case %0d done", i);
        end
        // full load with reset values, a refused write and a stalled byte
        do_reset(1'b1, 1'($urandom), 1'b1);
        `CHK("pc", 32'h0004_0004, core_pc_o)
        bus(1'b0, 5'h08, 32'h0);
        `CHK("dma_ctl", 32'h0000_04a1, q)
        bus(1'b0, 5'h04, 32'h0);
        `CHK("wait_cfg", 32'h0000_001e, q)
        bus(1'b0, 5'h02, 32'h0);
        `CHK("unmapped", 32'h0, q)
        bus(1'b1, 5'h10, 32'h0000_0055); // counts are not writable
        bus(1'b0, 5'h10, 32'h0);
        `CHK("int_cnt", NW, q)
        stall = 10 + $urandom % 10;
        while (rd_n !== 1'b0) @(posedge core_clk_i);
        hold <= 1'b1;
        repeat (stall) @(posedge core_clk_i);
        hold <= 1'b0;
        wait_rti();
        `CHK("stall", 1'b1, max_run >= stall)
        `CHK("words", NW, wq.size())
        for (int w = 0; w < NW; w++) begin
            `CHK("waddr", 32'h0004_0000 + w, wq[w][79:48])
            `CHK("wdata", exp_word(w), wq[w][47:0])
        end
        `CHK("idle_end", 1'b0, idle)
        `CHK("pc_end", 32'h0004_0000, core_pc_o)
        $display("test 2 done");
        // boot space, three-state and core requests; no other engine used
        `CHK("msel_off", 1'b0, msel_en)
        core_ext_req_i <= 1'b1;
        bus(1'b1, 5'h00, 32'h0000_0003);
        @(posedge core_clk_i);
        `CHK("sel_core", 1'b1, bms_o)
        `CHK("tristate", 1'b0, bms_oe)
        bus(1'b1, 5'h00, 32'h0);
        `CHK("msel_on", 1'b1, msel_en)
        `CHK("sel_off", 1'b1, bms_o)
        core_ext_req_i <= 1'b0;
        $display("test 3 done");
        // internal wait only: a stuck-low ack no longer blocks the load
        do_reset(1'b1, 1'b0, 1'b1);
        bus(1'b1, 5'h04, 32'h0000_000e);
        hold <= 1'b1;
        wait_rti();
        hold <= 1'b0;
        $display("test 4 done");
        give_verdict();
    end
endmodule // tb_boot_mode_eprom_loader
